// ==== common/pirt_pkg.sv ====
// What this block does
// - rate writes ignored while feature enabled
// - hold sixteen-bit periodic rate value
// - autonomous clock timeout is 2*(rate+1) periods
// - bus clock timeout is 2*(rate+1) periods
// - factory test writes only in special mode
// - offset enable bit gates thermal trim bits
// - thermal trim bits binary weighted offset
// - load thermal trim from flash after reset
// - oscillator trim writes only while unlocked
// - trim write under pll clears lock status
// - upper four trim bits coarse adjust
// - lower six trim bits fine adjust
// - load oscillator trim from flash after reset
// - four-bit temperature coefficient trim field
// - setting feature enable starts the timer
// - timeout sets flag; write one clears
// - clock select zero autonomous, one bus
//
// package: register map, field layout, reset values and carriers of
// the periodic interrupt timer and clock-unit trim block.
// assumes an 8-bit register port and a flash loader on the core clock.
package pirt_pkg;
	localparam int          ADDR_W           = 16;
	localparam int          DATA_W           = 8;
	// register byte offsets
	localparam logic [15:0] OFF_CTL          = 16'h02F2;
	localparam logic [15:0] OFF_RATE_HI      = 16'h02F4;
	localparam logic [15:0] OFF_RATE_LO      = 16'h02F5;
	localparam logic [15:0] OFF_TEST         = 16'h02F6;
	localparam logic [15:0] OFF_THERM        = 16'h02F7;
	localparam logic [15:0] OFF_OSC_HI       = 16'h02F8;
	localparam logic [15:0] OFF_OSC_LO       = 16'h02F9;
	localparam logic [15:0] OFF_IRQ_STAT     = 16'h02FA;
	localparam logic [15:0] OFF_IRQ_CLR      = 16'h02FB;
	localparam logic [15:0] OFF_IRQ_EN       = 16'h02FC;
	// control register fields
	localparam int          CTL_CLK_SEL_BIT  = 7;
	localparam int          CTL_ENABLE_BIT   = 2;
	localparam int          CTL_FLAG_BIT     = 0;
	// thermal trim register fields
	localparam int          THERM_EN_BIT     = 7;
	// oscillator trim high register fields
	localparam int          OSC_TC_LSB       = 4;
	// interrupt status bits
	localparam int          IRQ_W            = 2;
	localparam int          IRQ_TIMEOUT_BIT  = 0;
	localparam int          IRQ_REFUSED_BIT  = 1;
	// reset values
	localparam logic [15:0] RATE_RST         = 16'h0000;
	localparam logic [7:0]  TEST_RST         = 8'h00;
	localparam logic [3:0]  THERM_TRIM_RST   = 4'hF;
	localparam logic [9:0]  OSC_FREQ_RST     = 10'h3FF;
	localparam logic [3:0]  OSC_TC_RST       = 4'hF;
	// factory trim word delivered by the flash loader
	typedef struct packed {
		logic [3:0] thermal_trim;
		logic [3:0] tempco_trim;
		logic [9:0] freq_trim;
	} pirt_flash_s;
	// oscillator trim outputs
	typedef struct packed {
		logic [3:0] tempco;
		logic [3:0] coarse;
		logic [5:0] fine;
	} pirt_osc_trim_s;
endpackage

// ==== core/pirt_core.sv ====
// core: periodic wake-up timer with rate, clock select and flag,
// thermal offset trim, factory test byte and oscillator trims.
// assumes lock, pll select, special mode and flash data come from
// core-clock logic; the autonomous clock arrives on a free pin.
`timescale 1ns/1ps
`default_nettype none
module pirt_core (
	input  wire logic                        i_core_clk,
	input  wire logic                        i_rstn,
	input  wire logic [pirt_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [pirt_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	output logic      [pirt_pkg::DATA_W-1:0] o_rdata,
	input  wire logic                        i_aclk,
	input  wire logic                        i_clock_config_lock,
	input  wire logic                        i_pll_clock_select,
	input  wire logic                        i_special_mode,
	input  wire logic                        i_flash_valid,
	input  wire pirt_pkg::pirt_flash_s       i_flash,
	output logic                             o_trim_loaded,
	output logic                             o_timeout,
	output logic                             o_period_elapsed_flag,
	output logic                             o_irq,
	output logic                             o_lock_status_clear,
	output logic [7:0]                       o_factory_test,
	output logic                             o_thermal_offset_enable,
	output logic [3:0]                       o_thermal_offset,
	output pirt_pkg::pirt_osc_trim_s         o_osc_trim
);
	import pirt_pkg::*;

	logic [15:0]       rate_q;
	logic              clk_sel_q;
	logic              enable_q;
	logic              flag_q;
	logic [7:0]        test_q;
	logic              therm_en_q;
	logic [3:0]        therm_trim_q;
	logic [9:0]        freq_q;
	logic [3:0]        tc_q;
	logic [IRQ_W-1:0]  stat_q;
	logic [IRQ_W-1:0]  ien_q;
	logic              load_pend_q;
	logic              aclk_s1_q;
	logic              aclk_s2_q;
	logic              aclk_s3_q;
	logic [16:0]       cnt_q;
	logic              timeout_q;
	logic              lock_clr_q;
	logic              irq_q;
	logic [7:0]        rdata_q;
	logic [3:0]        therm_out_q;
	logic              wr_ctl;
	logic              wr_rate_hi;
	logic              wr_rate_lo;
	logic              wr_test;
	logic              wr_therm;
	logic              wr_osc_hi;
	logic              wr_osc_lo;
	logic              wr_osc;
	logic              osc_ok;
	logic              osc_refused;
	logic              flash_take;
	logic              tick;
	logic [16:0]       term;
	logic              term_hit;
	logic [IRQ_W-1:0]  events;

	// write decode
	assign wr_ctl      = i_wr && (i_addr == OFF_CTL);
	assign wr_rate_hi  = i_wr && (i_addr == OFF_RATE_HI);
	assign wr_rate_lo  = i_wr && (i_addr == OFF_RATE_LO);
	assign wr_test     = i_wr && (i_addr == OFF_TEST);
	assign wr_therm    = i_wr && (i_addr == OFF_THERM);
	assign wr_osc_hi   = i_wr && (i_addr == OFF_OSC_HI);
	assign wr_osc_lo   = i_wr && (i_addr == OFF_OSC_LO);
	assign wr_osc      = wr_osc_hi || wr_osc_lo;
	assign osc_ok      = wr_osc && !i_clock_config_lock;
	assign osc_refused = wr_osc && i_clock_config_lock;
	assign flash_take  = load_pend_q && i_flash_valid;

	// autonomous clock pin synchroniser and edge history
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			aclk_s1_q <= 1'b0;
			aclk_s2_q <= 1'b0;
			aclk_s3_q <= 1'b0;
		end else begin
			aclk_s1_q <= i_aclk;
			aclk_s2_q <= aclk_s1_q;
			aclk_s3_q <= aclk_s2_q;
		end
	end

	// timer tick: every bus cycle or each rising autonomous edge
	assign tick = clk_sel_q ? 1'b1 : (aclk_s2_q && !aclk_s3_q);
	// last count of a period, 2*(rate+1) ticks in all
	assign term     = {rate_q, 1'b1};
	assign term_hit = enable_q && tick && (cnt_q == term);

	// control register: clock select frozen while enabled, and also
	// refused by the very write that sets enable
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			clk_sel_q <= 1'b0;
			enable_q  <= 1'b0;
		end else if (wr_ctl) begin
			if (!enable_q && !i_wdata[CTL_ENABLE_BIT]) begin
				clk_sel_q <= i_wdata[CTL_CLK_SEL_BIT];
			end
			enable_q <= i_wdata[CTL_ENABLE_BIT];
		end
	end

	// periodic rate, byte-wise, only while the timer is disabled
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			rate_q <= RATE_RST;
		end else if (!enable_q) begin
			if (wr_rate_hi) begin
				rate_q[15:8] <= i_wdata;
			end
			if (wr_rate_lo) begin
				rate_q[7:0] <= i_wdata;
			end
		end
	end

	// period counter, restarts from zero at each timeout
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			cnt_q <= 17'h00000;
		end else if (!enable_q) begin
			cnt_q <= 17'h00000;
		end else if (term_hit) begin
			cnt_q <= 17'h00000;
		end else if (tick) begin
			cnt_q <= cnt_q + 17'h00001;
		end
	end

	// period elapsed flag: write one clears, a new timeout wins
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			flag_q <= 1'b0;
		end else if (term_hit) begin
			flag_q <= 1'b1;
		end else if (wr_ctl && i_wdata[CTL_FLAG_BIT]) begin
			flag_q <= 1'b0;
		end
	end

	// timeout pulse out
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			timeout_q <= 1'b0;
		end else begin
			timeout_q <= term_hit;
		end
	end

	// factory test byte, writable in special mode only
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			test_q <= TEST_RST;
		end else if (wr_test && i_special_mode) begin
			test_q <= i_wdata;
		end
	end

	// flash load pending from reset until the loader delivers
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			load_pend_q <= 1'b1;
		end else if (i_flash_valid) begin
			load_pend_q <= 1'b0;
		end
	end

	// thermal trim: flash load beats a software write
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			therm_en_q   <= 1'b0;
			therm_trim_q <= THERM_TRIM_RST;
		end else if (flash_take) begin
			therm_trim_q <= i_flash.thermal_trim;
		end else if (wr_therm) begin
			therm_en_q   <= i_wdata[THERM_EN_BIT];
			therm_trim_q <= i_wdata[3:0];
		end
	end

	// offset out: binary weighted code, forced to zero when disabled
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			therm_out_q <= 4'h0;
		end else begin
			therm_out_q <= therm_en_q ? therm_trim_q : 4'h0;
		end
	end

	// oscillator trims: flash load first, then unlocked writes
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			freq_q <= OSC_FREQ_RST;
			tc_q   <= OSC_TC_RST;
		end else if (flash_take) begin
			freq_q <= i_flash.freq_trim;
			tc_q   <= i_flash.tempco_trim;
		end else if (osc_ok) begin
			if (wr_osc_hi) begin
				tc_q        <= i_wdata[OSC_TC_LSB+3:OSC_TC_LSB];
				freq_q[9:8] <= i_wdata[1:0];
			end else begin
				freq_q[7:0] <= i_wdata;
			end
		end
	end

	// lock and oscillator-up clear request on accepted pll writes
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			lock_clr_q <= 1'b0;
		end else begin
			lock_clr_q <= osc_ok && i_pll_clock_select;
		end
	end

	// sticky interrupt status: set beats clear in the same cycle
	assign events = {osc_refused, term_hit};
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			stat_q <= '0;
		end else if (i_wr && (i_addr == OFF_IRQ_CLR)) begin
			stat_q <= (stat_q & ~i_wdata[IRQ_W-1:0]) | events;
		end else begin
			stat_q <= stat_q | events;
		end
	end

	// interrupt enable and level output
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			ien_q <= '0;
			irq_q <= 1'b0;
		end else begin
			if (i_wr && (i_addr == OFF_IRQ_EN)) begin
				ien_q <= i_wdata[IRQ_W-1:0];
			end
			irq_q <= |(stat_q & ien_q);
		end
	end

	// read data stand for the single cycle after the strobe
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			rdata_q <= 8'h00;
		end else if (!i_rd) begin
			rdata_q <= 8'h00;
		end else begin
			unique case (i_addr)
				OFF_CTL:      rdata_q <= {clk_sel_q, 4'h0, enable_q,
				                         1'b0, flag_q};
				OFF_RATE_HI:  rdata_q <= rate_q[15:8];
				OFF_RATE_LO:  rdata_q <= rate_q[7:0];
				OFF_TEST:     rdata_q <= test_q;
				OFF_THERM:    rdata_q <= {therm_en_q, 3'h0, therm_trim_q};
				OFF_OSC_HI:   rdata_q <= {tc_q, 2'h0, freq_q[9:8]};
				OFF_OSC_LO:   rdata_q <= freq_q[7:0];
				OFF_IRQ_STAT: rdata_q <= {6'h00, stat_q};
				OFF_IRQ_EN:   rdata_q <= {6'h00, ien_q};
				default:      rdata_q <= 8'h00; // unmapped and write-only
			endcase
		end
	end

	// outputs straight from flops
	assign o_rdata                 = rdata_q;
	assign o_trim_loaded           = !load_pend_q;
	assign o_timeout               = timeout_q;
	assign o_period_elapsed_flag   = flag_q;
	assign o_irq                   = irq_q;
	assign o_lock_status_clear     = lock_clr_q;
	assign o_factory_test          = test_q;
	assign o_thermal_offset_enable = therm_en_q;
	assign o_thermal_offset        = therm_out_q;
	assign o_osc_trim              = {tc_q, freq_q[9:6], freq_q[5:0]};

	// checks on the block's own behaviour
	default clocking chk_cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);

	rate_frozen_a: assert property (
		(wr_rate_hi || wr_rate_lo) && enable_q |=> $stable(rate_q))
		else $error("rate changed while timer enabled");

	period_end_a: assert property (
		timeout_q |-> $past(cnt_q) == {$past(rate_q), 1'b1})
		else $error("timeout at wrong count");

	bus_period_a: assert property (
		enable_q && clk_sel_q && cnt_q == 17'h00000 && rate_q == 16'h0000
		&& !wr_ctl
		|=> cnt_q == 17'h00001 ##1 cnt_q == 17'h00000 && timeout_q)
		else $error("bus clock period wrong for zero rate");

	test_guard_a: assert property (
		wr_test && !i_special_mode |=> $stable(test_q))
		else $error("test byte written outside special mode");

	therm_mask_a: assert property (
		!therm_en_q |=> o_thermal_offset == 4'h0)
		else $error("offset not masked when disabled");

	therm_load_a: assert property (
		flash_take |=> therm_trim_q == $past(i_flash.thermal_trim))
		else $error("thermal trim not loaded from flash");

	osc_lock_a: assert property (
		wr_osc && i_clock_config_lock && !flash_take
		|=> $stable(freq_q) && $stable(tc_q))
		else $error("osc trim changed while locked");

	lock_clear_a: assert property (
		osc_ok && i_pll_clock_select |=> o_lock_status_clear)
		else $error("lock status clear missing");

	osc_load_a: assert property (
		flash_take |=> freq_q == $past(i_flash.freq_trim))
		else $error("osc trim not loaded from flash");

	flag_set_a: assert property (
		term_hit |=> flag_q && timeout_q)
		else $error("flag not set on timeout");

	restart_a: assert property (
		term_hit |=> cnt_q == 17'h00000)
		else $error("counter not reloaded after timeout");

	irq_level_a: assert property (
		|(stat_q & ien_q) |=> o_irq)
		else $error("interrupt not raised");

	bus_timeout_c: cover property (term_hit && clk_sel_q);
	aclk_timeout_c: cover property (term_hit && !clk_sel_q);
	lock_clear_c: cover property (lock_clr_q);
	irq_c: cover property (irq_q);
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// testbench for the periodic timer and trim block: register table rows,
// flash load, timer periods in both clocks, lock and special-mode writes.
// assumes pirt_pkg and pirt_core are compiled first; no partner model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pirt_pkg::*;
	logic                   clk;
	logic                   rstn;
	logic [15:0]            addr;
	logic [7:0]             wdata;
	logic                   wr;
	logic                   rd;
	logic [7:0]             rdata;
	logic                   aclk;
	logic                   lock;
	logic                   pll;
	logic                   special;
	logic                   fvalid;
	pirt_flash_s            flash;
	logic                   loaded;
	logic                   tmo;
	logic                   flag;
	logic                   irq;
	logic                   lsclr;
	logic [7:0]             ftest;
	logic                   toe;
	logic [3:0]             toff;
	pirt_osc_trim_s         osc;
	int                     err_total;
	int                     n_tests;
	int                     cyc;
	int                     acnt;
	int                     n;
	logic [7:0]             v;
	logic [31:0]            rows [8];

	pirt_core pirt_core_inst (
		.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_aclk(aclk),
		.i_clock_config_lock(lock), .i_pll_clock_select(pll),
		.i_special_mode(special), .i_flash_valid(fvalid), .i_flash(flash),
		.o_trim_loaded(loaded), .o_timeout(tmo),
		.o_period_elapsed_flag(flag), .o_irq(irq),
		.o_lock_status_clear(lsclr), .o_factory_test(ftest),
		.o_thermal_offset_enable(toe), .o_thermal_offset(toff),
		.o_osc_trim(osc)
	);

	// 250 MHz core clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// autonomous clock: 20 core cycles per period, toggled on core clock edges
	always @(posedge clk) begin
		acnt <= (acnt == 9) ? 0 : acnt + 1;
		if (acnt == 9) begin
			aclk <= ~aclk;
		end
	end

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			complete_run();
		end
	end

	task automatic chk(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wrr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr    <= 1'b0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rdr(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		d = rdata;
	endtask

	// cycles between two timeout pulses, bounded
	task automatic gap(output int g);
		int k;
		k = 0;
		g = 0;
		while (tmo !== 1'b1 && k < 500) begin
			@(posedge clk);
			#1;
			k++;
		end
		@(posedge clk);
		#1;
		g = 1;
		while (tmo !== 1'b1 && g < 500) begin
			@(posedge clk);
			#1;
			g++;
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		{wr, rd, lock, pll, special, fvalid} = '0;
		{addr, wdata, acnt, cyc, err_total, n_tests} = '0;
		rstn  = 1'b0;
		aclk  = 1'b0;
		flash = '{thermal_trim: 4'h9, tempco_trim: 4'h6, freq_trim: 10'h2A5};
		rows  = '{{16'h02F4, 8'h12, 8'h12}, {16'h02F5, 8'h34, 8'h34},
			{16'h02F7, 8'h85, 8'h85}, {16'h02F8, 8'hA1, 8'hA1},
			{16'h02F9, 8'h5C, 8'h5C}, {16'h02F6, 8'h77, 8'h00},
			{16'h0300, 8'h55, 8'h00}, {16'h02FC, 8'h01, 8'h01}};
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		// values before the flash word arrives
		rdr(OFF_RATE_HI, v); chk("rate_hi_rst", v, 8'h00);
		rdr(OFF_THERM, v);   chk("therm_rst", v, 8'h0F);
		rdr(OFF_OSC_HI, v);  chk("osc_hi_rst", v, 8'hF3);
		chk("trim_loaded_rst", loaded, 1'b0);
		// flash load after reset
		@(posedge clk);
		fvalid <= 1'b1;
		@(posedge clk);
		fvalid <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("trim_loaded", loaded, 1'b1);
		chk("osc_trim_flash", osc, {4'h6, 4'hA, 6'h25});
		rdr(OFF_THERM, v); chk("therm_flash", v, 8'h09);
		chk("toff_flash", toff, 4'h0);
		// register table rows: write then read back
		foreach (rows[i]) begin
			wrr(rows[i][31:16], rows[i][15:8]);
			rdr(rows[i][31:16], v);
			chk("row_read", v, rows[i][7:0]);
		end
		chk("toff_on", {toe, toff}, 5'h15);
		chk("osc_trim_wr", osc, {4'hA, 4'h5, 6'h1C});
		wrr(OFF_THERM, 8'h05);
		@(posedge clk);
		#1;
		chk("toff_off", {toe, toff}, 5'h00);
		// trim write under pll clears lock status; locked write is lost
		pll <= 1'b1;
		wrr(OFF_OSC_LO, 8'h5D);
		chk("lock_clear", lsclr, 1'b1);
		lock <= 1'b1;
		wrr(OFF_OSC_LO, 8'h00);
		chk("lock_clear_locked", lsclr, 1'b0);
		rdr(OFF_OSC_LO, v); chk("osc_lo_locked", v, 8'h5D);
		rdr(OFF_IRQ_STAT, v); chk("stat_refused", v, 8'h02);
		wrr(OFF_IRQ_CLR, 8'h02);
		rdr(OFF_IRQ_STAT, v); chk("stat_clr", v, 8'h00);
		// special mode opens the test byte
		special <= 1'b1;
		wrr(OFF_TEST, 8'h3C);
		chk("test_out", ftest, 8'h3C);
		// bus clock timer, rate 2 gives 6 cycles
		wrr(OFF_RATE_HI, 8'h00);
		wrr(OFF_RATE_LO, 8'h02);
		wrr(OFF_CTL, 8'h80);
		wrr(OFF_CTL, 8'h84);
		gap(n); chk("period_bus", n, 6);
		gap(n); chk("period_bus_2", n, 6);
		chk("flag_set", flag, 1'b1);
		chk("irq_set", irq, 1'b1);
		wrr(OFF_RATE_LO, 8'hFF);
		rdr(OFF_RATE_LO, v); chk("rate_locked", v, 8'h02);
		wrr(OFF_CTL, 8'h80);
		wrr(OFF_CTL, 8'h80);
		chk("flag_w0", flag, 1'b1);
		wrr(OFF_CTL, 8'h81);
		@(posedge clk);
		#1;
		chk("flag_w1c", flag, 1'b0);
		wrr(OFF_IRQ_CLR, 8'h01);
		repeat (2) @(posedge clk);
		#1;
		chk("irq_clr", irq, 1'b0);
		// autonomous clock timer, rate 0 gives two periods of 20 cycles
		wrr(OFF_CTL, 8'h00);
		wrr(OFF_RATE_LO, 8'h00);
		wrr(OFF_CTL, 8'h04);
		gap(n); chk("period_aclk", n, 40);
		wrr(OFF_CTL, 8'h01);
		// select refused by the write that sets enable
		wrr(OFF_CTL, 8'h84);
		rdr(OFF_CTL, v); chk("sel_same_write", v, 8'h04);
		wrr(OFF_CTL, 8'h00);
		// bus clock timer at rate 0: shortest period of 2 cycles
		wrr(OFF_CTL, 8'h80);
		wrr(OFF_CTL, 8'h84);
		gap(n); chk("period_bus_min", n, 2);
		wrr(OFF_CTL, 8'h01);
		complete_run();
	end
endmodule
`default_nettype wire
